// ### logic/spwc_pkg.sv
// Constants, types and helpers shared by the sleep power and wake control block.
package spwc_pkg;

  // ----------------------------------------------------------------------
  // Register indices; the APB byte address is four times the index.
  // ----------------------------------------------------------------------
  localparam logic [7:0] IDX_GATE_LO = 8'h0C; // Peripheral clock gates, low byte.
  localparam logic [7:0] IDX_GATE_HI = 8'h0D; // Peripheral clock gates, high byte.
  localparam logic [7:0] IDX_WAKE    = 8'h0E; // Wake event configuration.
  localparam logic [7:0] IDX_PWR     = 8'h0F; // Peripheral sleep power control.
  localparam logic [7:0] IDX_PLAN    = 8'h20; // Sleep power plan.
  localparam logic [7:0] IDX_AUX     = 8'h22; // Auxiliary supply adjust.
  localparam logic [7:0] IDX_BAT     = 8'h24; // Battery detect control.
  localparam logic [7:0] IDX_SIG     = 8'h28; // Unlock signature, reads status.

  // ----------------------------------------------------------------------
  // Values after reset.
  // ----------------------------------------------------------------------
  localparam logic [7:0]  RST_WAKE    = 8'h20;   // Battery wake enabled.
  localparam logic [15:0] RST_PLAN    = 16'h11DF;
  localparam logic [15:0] RST_AUX     = 16'h0022; // Trim 010, kept bits 100.
  localparam logic [3:0]  AUX_RO_BITS = 4'h0;    // Read-only trim readback.

  // ----------------------------------------------------------------------
  // Field positions.
  // ----------------------------------------------------------------------
  localparam int WK_PIN_MODE = 7;
  localparam int WK_LATCH    = 6;
  localparam int WK_BAT      = 5;
  localparam int WK_PIN      = 4;
  localparam int WK_RTC      = 3;
  localparam int WK_ANY_EDGE = 2;
  localparam int WK_HSUSB    = 1;
  localparam int WK_FSUSB    = 0;
  localparam int PL_ARM      = 15;
  localparam int PL_BIAS     = 10;
  localparam int PL_DCDC     = 9;
  localparam int AX_DCDC     = 7;
  localparam int BT_LOW_IE   = 3;
  localparam int BT_VLOW_IE  = 2;
  localparam int BT_MON      = 1;
  localparam int BT_VTHX     = 0;

  // ----------------------------------------------------------------------
  // Settling counts after wake, in system clock cycles.
  // ----------------------------------------------------------------------
  localparam logic [11:0] DLY_NONE  = 12'h008; // 8 cycles.
  localparam logic [11:0] DLY_ULTRA = 12'h046; // 70 cycles.
  localparam logic [11:0] DLY_SHORT = 12'h208; // 520 cycles.
  localparam logic [11:0] DLY_LONG  = 12'hE06; // 3590 cycles.

  // ----------------------------------------------------------------------
  // Unlock sequence.
  // ----------------------------------------------------------------------
  localparam logic [7:0] SIG_FIRST   = 8'h57;
  localparam logic [7:0] SIG_SECOND  = 8'hA8;
  localparam logic [7:0] SAFE_WINDOW = 8'h20; // Cycles the unlock stays open.

  typedef enum logic [2:0] {
    ST_RUN    = 3'b001,
    ST_SLEEP  = 3'b010,
    ST_SETTLE = 3'b100
  } spwc_state_t;

  // Settling count chosen by the two-bit delay selector.
  function automatic logic [11:0] wake_delay(input logic [1:0] sel);
    case (sel)
      2'b11:   wake_delay = DLY_NONE;
      2'b10:   wake_delay = DLY_ULTRA;
      2'b01:   wake_delay = DLY_SHORT;
      default: wake_delay = DLY_LONG;
    endcase
  endfunction

  // True for every index that holds a register.
  function automatic logic reg_mapped(input logic [7:0] idx);
    reg_mapped = (idx == IDX_GATE_LO) || (idx == IDX_GATE_HI) || (idx == IDX_WAKE) ||
                 (idx == IDX_PWR) || (idx == IDX_PLAN) || (idx == IDX_AUX) ||
                 (idx == IDX_BAT) || (idx == IDX_SIG);
  endfunction

endpackage

// ### logic/spwc_unlock_if.sv
// Carrier between the register front end and the unlock sequencer.
`timescale 1ns/1ps
interface spwc_unlock_if;
  logic       sig_wr;   // One-cycle pulse: signature register written.
  logic [7:0] sig_data; // Byte written to the signature register.
  logic       unlocked; // Protected fields may be written.
  logic [7:0] timer;    // Cycles left in the open window.
  modport ctl  (output sig_wr, output sig_data, input unlocked, input timer);
  modport lock (input sig_wr, input sig_data, output unlocked, output timer);
endinterface

// ### logic/spwc_unlock.sv
// Unlock sequencer that opens a short window for protected writes.
`timescale 1ns/1ps
module spwc_unlock (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  spwc_unlock_if.lock     lk
);

  // ----------------------------------------------------------------------
  // State.
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic       armed; // First signature byte seen.
    logic       open;  // Window open.
    logic [7:0] timer; // Remaining window cycles.
  } spwc_lock_st_t;

  spwc_lock_st_t s_q;
  spwc_lock_st_t s_d;

  // Any signature write other than the expected next byte relocks, so a
  // runaway write cannot leave the window open.
  always_comb begin
    s_d = s_q;
    if (lk.sig_wr) begin
      if (lk.sig_data == spwc_pkg::SIG_FIRST) begin
        s_d.armed = 1'b1;
        s_d.open  = 1'b0;
      end else if (s_q.armed && lk.sig_data == spwc_pkg::SIG_SECOND) begin
        s_d.armed = 1'b0;
        s_d.open  = 1'b1;
        s_d.timer = spwc_pkg::SAFE_WINDOW;
      end else begin
        s_d.armed = 1'b0;
        s_d.open  = 1'b0;
        s_d.timer = 8'h00;
      end
    end else if (s_q.open) begin
      s_d.timer = s_q.timer - 8'h01;
      s_d.open  = (s_q.timer != 8'h01);
    end
  end

  // Registers the state.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign lk.unlocked = s_q.open;
  assign lk.timer    = s_q.timer;

endmodule

// ### logic/spwc_top.sv
// Sleep power and wake control block with its APB register front end.
//
// The placing of the registers and the APB register port were decided locally.
`timescale 1ns/1ps
module spwc_top (
  input  wire logic        REF_CLK_I,          // System clock, 40 MHz.
  input  wire logic        SYS_RST_I,          // Asynchronous reset, active high.
  input  wire logic        PSEL_I,             // APB select.
  input  wire logic        PENABLE_I,          // APB access phase.
  input  wire logic        PWRITE_I,           // APB direction.
  input  wire logic [11:0] PADDR_I,            // APB byte address.
  input  wire logic [31:0] PWDATA_I,           // APB write data.
  output logic      [31:0] PRDATA_O,           // APB read data.
  output logic             PREADY_O,           // APB ready.
  output logic             PSLVERR_O,          // APB error, unmapped address.
  input  wire logic        LP_ENTRY_I,         // Pulse: core enters sleep.
  input  wire logic        LP_WFE_I,           // Entry was by wait-for-event.
  input  wire logic        PIN_EDGE_EVT_I,     // Pin event on configured edge.
  input  wire logic        PIN_ANY_EDGE_I,     // Pin event on either edge.
  input  wire logic        RTC_EVT_I,          // Real-time clock event.
  input  wire logic        HSUSB_EVT_I,        // High-speed USB event.
  input  wire logic        FSUSB_EVT_I,        // Full-speed USB event.
  input  wire logic        BAT_WAKE_EVT_I,     // Battery low-voltage wake event.
  input  wire logic        BAT_LOW_I,          // Battery below low threshold.
  input  wire logic        BAT_VLOW_I,         // Battery below very-low threshold.
  output logic      [15:0] PERIPH_CLK_OFF_O,   // Peripheral clock stops.
  output logic      [2:0]  SRAM_CLK_OFF_O,     // PHY, main SRAM, small SRAM stops.
  output logic      [1:0]  RETAIN_LEVEL_O,     // Retention supply level.
  output logic             DCDC_BIAS_EN_O,     // Converter bias.
  output logic             DCDC_EN_O,          // Main converter.
  output logic             DIRECT_SUPPLY_EN_O, // Direct supply path.
  output logic      [6:0]  SUPPLY_KEEP_O,      // Domain supplies kept.
  output logic             AUX_DCDC_EN_O,      // Auxiliary converter.
  output logic      [2:0]  ULP_TRIM_O,         // Regulator trim code.
  output logic             BAT_MON_EN_O,       // Battery monitor enable.
  output logic             BAT_THR_MSB_O,      // Monitor threshold top bit.
  output logic             BAT_HP_DET_EN_O,    // Precision detection enable.
  output logic             BAT_LOW_IRQ_O,      // Low-voltage interrupt request.
  output logic             BAT_VLOW_IRQ_O,     // Very-low interrupt request.
  output logic             SLEEPING_O,         // Core held in sleep or settling.
  output logic             WAKE_DONE_O         // Pulse: settling finished.
);

  // ----------------------------------------------------------------------
  // State.
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [7:0]           gate_lo;  // Serial port and timer clock stops.
    logic [7:0]           gate_hi;  // Radio, display, USB, bus clock stops.
    logic [7:0]           wake;     // Wake configuration.
    logic [7:0]           pwr;      // Sleep power control.
    logic [15:0]          plan;     // Power plan.
    logic [15:0]          aux;      // Auxiliary supply adjust.
    logic [7:0]           bat;      // Battery detect control.
    spwc_pkg::spwc_state_t st;      // Sleep sequence state.
    logic                 wfe;      // Sleep was entered by wait-for-event.
    logic [4:0]           pend;     // Pending wake sources.
    logic [11:0]          dly;      // Settling countdown.
    logic                 done;     // Wake finished pulse.
    logic [6:0]           supply;   // Applied domain supplies.
    logic [1:0]           retain;   // Applied retention level.
    logic                 direct;   // Direct supply path on.
    logic                 irq_low;  // Gated low interrupt.
    logic                 irq_vlow; // Gated very-low interrupt.
    logic                 hp_det;   // Precision detection on.
    logic                 thr_msb;  // Threshold top bit in use.
    logic                 sleeping; // Not running.
    logic [31:0]          prdata;   // Read data.
    logic                 pready;   // Ready.
    logic                 pslverr;  // Error.
  } spwc_st_t;

  spwc_st_t s_q;
  spwc_st_t s_d;

  // ----------------------------------------------------------------------
  // Bus decode.
  // ----------------------------------------------------------------------
  logic [7:0] idx;     // Register index.
  logic       mapped;  // Address hits a register.
  logic       wr_en;   // Write completes this edge.
  logic       prot_wr; // Write allowed to change protected fields.
  logic [4:0] ev_now;  // Enabled wake events this cycle.
  logic       pin_evt; // Pin event under the selected edge mode.

  spwc_unlock_if u_if ();

  assign idx     = PADDR_I[9:2];
  assign mapped  = (PADDR_I[1:0] == 2'b00) && (PADDR_I[11:10] == 2'b00) &&
                   spwc_pkg::reg_mapped(idx);
  assign wr_en   = PSEL_I & PENABLE_I & s_q.pready & PWRITE_I & mapped;
  assign prot_wr = wr_en & u_if.unlocked;

  assign u_if.sig_wr   = wr_en && (idx == spwc_pkg::IDX_SIG);
  assign u_if.sig_data = PWDATA_I[7:0];

  spwc_unlock u_lock (
    .clk_i (REF_CLK_I),
    .rst_i (SYS_RST_I),
    .lk    (u_if.lock)
  );

  // ----------------------------------------------------------------------
  // Wake sources.
  // ----------------------------------------------------------------------
  // Either-edge detection only works when the core waits for an event, so
  // the any-edge input is ignored after an interrupt-style entry.
  assign pin_evt = s_q.wake[spwc_pkg::WK_ANY_EDGE] ? (PIN_ANY_EDGE_I & s_q.wfe)
                                                   : PIN_EDGE_EVT_I;
  assign ev_now = {BAT_WAKE_EVT_I & s_q.wake[spwc_pkg::WK_BAT],
                   pin_evt & s_q.wake[spwc_pkg::WK_PIN] &
                   s_q.wake[spwc_pkg::WK_PIN_MODE],
                   RTC_EVT_I & s_q.wake[spwc_pkg::WK_RTC],
                   HSUSB_EVT_I & s_q.wake[spwc_pkg::WK_HSUSB],
                   FSUSB_EVT_I & s_q.wake[spwc_pkg::WK_FSUSB]};

  // ----------------------------------------------------------------------
  // Next state.
  // ----------------------------------------------------------------------
  always_comb begin
    s_d        = s_q;
    s_d.done   = 1'b0;
    s_d.pready = PSEL_I & ~PENABLE_I;
    // Read data and error are prepared in the setup cycle so the access
    // phase answers from flip-flops with no extra wait.
    if (PSEL_I && !PENABLE_I) begin
      s_d.pslverr = ~mapped;
      s_d.prdata  = 32'h0000_0000;
      if (mapped) begin
        case (idx)
          spwc_pkg::IDX_GATE_LO: s_d.prdata = {24'h00_0000, s_q.gate_lo};
          spwc_pkg::IDX_GATE_HI: s_d.prdata = {24'h00_0000, s_q.gate_hi};
          spwc_pkg::IDX_WAKE:    s_d.prdata = {24'h00_0000, s_q.wake};
          spwc_pkg::IDX_PWR:     s_d.prdata = {24'h00_0000, s_q.pwr};
          spwc_pkg::IDX_PLAN:    s_d.prdata = {16'h0000, s_q.plan};
          spwc_pkg::IDX_AUX:     s_d.prdata = {16'h0000, s_q.aux};
          spwc_pkg::IDX_BAT:     s_d.prdata = {24'h00_0000, s_q.bat};
          default:               s_d.prdata = {16'h0000, u_if.timer, 4'h0,
                                               s_q.st, u_if.unlocked};
        endcase
      end
    end

    // Sleep sequence.
    unique case (s_q.st)
      spwc_pkg::ST_RUN: begin
        s_d.pend = 5'h00;
        if (LP_ENTRY_I) begin
          s_d.st     = spwc_pkg::ST_SLEEP;
          s_d.wfe    = LP_WFE_I;
          s_d.retain = s_q.pwr[7:6];
          if (s_q.plan[spwc_pkg::PL_ARM]) begin
            s_d.supply = {s_q.plan[8:7], s_q.plan[4:0]};
            s_d.plan[spwc_pkg::PL_ARM] = 1'b0;
          end
        end
      end
      spwc_pkg::ST_SLEEP: begin
        // Without latching pend follows the enabled sources each cycle; with
        // latching it accumulates. Either way a single-cycle pulse starts the wake.
        s_d.pend = s_q.wake[spwc_pkg::WK_LATCH] ? (s_q.pend | ev_now) : ev_now;
        if (|s_d.pend) begin
          s_d.st  = spwc_pkg::ST_SETTLE;
          s_d.dly = spwc_pkg::wake_delay(s_q.pwr[1:0]) - 12'h001;
        end
      end
      spwc_pkg::ST_SETTLE: begin
        if (s_q.dly == 12'h000) begin
          s_d.st     = spwc_pkg::ST_RUN;
          s_d.done   = 1'b1;
          s_d.supply = 7'h7F;
          s_d.retain = 2'b00;
          s_d.pend   = 5'h00;
        end else begin
          s_d.dly = s_q.dly - 12'h001;
        end
      end
    endcase

    // Register writes; a software arm in the same cycle as the hardware
    // clear above wins, so the plan is kept for the next entry.
    if (prot_wr) begin
      case (idx)
        spwc_pkg::IDX_GATE_LO: s_d.gate_lo = PWDATA_I[7:0];
        spwc_pkg::IDX_GATE_HI: s_d.gate_hi = PWDATA_I[7:0];
        spwc_pkg::IDX_WAKE:    s_d.wake    = PWDATA_I[7:0];
        spwc_pkg::IDX_PWR:     s_d.pwr     = {PWDATA_I[7:4], 1'b0, PWDATA_I[2:0]};
        spwc_pkg::IDX_PLAN:    s_d.plan    = {PWDATA_I[15:6], 1'b0, PWDATA_I[4:0]};
        spwc_pkg::IDX_AUX:     s_d.aux     = {4'h0, spwc_pkg::AUX_RO_BITS, PWDATA_I[7],
                                              1'b0, PWDATA_I[5:0]};
        spwc_pkg::IDX_BAT:     s_d.bat     = {4'h0, PWDATA_I[3:0]};
        default:               s_d.bat     = s_q.bat;
      endcase
    end

    // Derived outputs, held in flip-flops.
    s_d.direct   = ~s_d.plan[spwc_pkg::PL_DCDC];
    s_d.irq_low  = BAT_LOW_I & s_d.bat[spwc_pkg::BT_LOW_IE];
    s_d.irq_vlow = BAT_VLOW_I & s_d.bat[spwc_pkg::BT_VLOW_IE];
    s_d.thr_msb  = s_d.bat[spwc_pkg::BT_MON] & s_d.bat[spwc_pkg::BT_VTHX];
    s_d.hp_det   = ~s_d.bat[spwc_pkg::BT_MON] & s_d.bat[spwc_pkg::BT_VTHX];
    s_d.sleeping = (s_d.st != spwc_pkg::ST_RUN);
  end

  // ----------------------------------------------------------------------
  // State register.
  // ----------------------------------------------------------------------
  always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      s_q        <= '0;
      s_q.wake   <= spwc_pkg::RST_WAKE;
      s_q.plan   <= spwc_pkg::RST_PLAN;
      s_q.aux    <= spwc_pkg::RST_AUX;
      s_q.st     <= spwc_pkg::ST_RUN;
      s_q.supply <= 7'h7F;
      s_q.direct <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs, all straight from the state register.
  // ----------------------------------------------------------------------
  assign PRDATA_O           = s_q.prdata;
  assign PREADY_O           = s_q.pready;
  assign PSLVERR_O          = s_q.pslverr;
  assign PERIPH_CLK_OFF_O   = {s_q.gate_hi, s_q.gate_lo};
  assign SRAM_CLK_OFF_O     = {s_q.pwr[2], s_q.pwr[4], s_q.pwr[5]};
  assign RETAIN_LEVEL_O     = s_q.retain;
  assign DCDC_BIAS_EN_O     = s_q.plan[spwc_pkg::PL_BIAS];
  assign DCDC_EN_O          = s_q.plan[spwc_pkg::PL_DCDC];
  assign DIRECT_SUPPLY_EN_O = s_q.direct;
  assign SUPPLY_KEEP_O      = s_q.supply;
  assign AUX_DCDC_EN_O      = s_q.aux[spwc_pkg::AX_DCDC];
  assign ULP_TRIM_O         = s_q.aux[2:0];
  assign BAT_MON_EN_O       = s_q.bat[spwc_pkg::BT_MON];
  assign BAT_THR_MSB_O      = s_q.thr_msb;
  assign BAT_HP_DET_EN_O    = s_q.hp_det;
  assign BAT_LOW_IRQ_O      = s_q.irq_low;
  assign BAT_VLOW_IRQ_O     = s_q.irq_vlow;
  assign SLEEPING_O         = s_q.sleeping;
  assign WAKE_DONE_O        = s_q.done;

  // ----------------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------------
  default clocking cb @(posedge REF_CLK_I);
  endclocking
  default disable iff (SYS_RST_I);

  // A settle window is recognised by its first cycle; the selector must not move under it.
  sequence settle_fast;
    $rose(s_q.st == spwc_pkg::ST_SETTLE) && $stable(s_q.pwr) && s_q.pwr[1:0] == 2'b11;
  endsequence
  sequence settle_ultra;
    $rose(s_q.st == spwc_pkg::ST_SETTLE) && $stable(s_q.pwr) && s_q.pwr[1:0] == 2'b10;
  endsequence
  sequence armed_entry;
    LP_ENTRY_I && s_q.st == spwc_pkg::ST_RUN && s_q.plan[spwc_pkg::PL_ARM] && !wr_en;
  endsequence

  a_gate_low_write: assert property (
    prot_wr && idx == spwc_pkg::IDX_GATE_LO |=> PERIPH_CLK_OFF_O[7:0] == $past(PWDATA_I[7:0])
  ) else $error("Low clock gate write not taken.");
  a_gate_high_write: assert property (
    prot_wr && idx == spwc_pkg::IDX_GATE_HI |=> PERIPH_CLK_OFF_O[15:8] == $past(PWDATA_I[7:0])
  ) else $error("High clock gate write not taken.");
  a_locked_hold: assert property (
    wr_en && !u_if.unlocked |=> $stable(PERIPH_CLK_OFF_O) && $stable(s_q.wake)
  ) else $error("Locked write changed a protected field.");
  a_delay_fast: assert property (
    settle_fast |-> (!WAKE_DONE_O)[*8] ##1 WAKE_DONE_O
  ) else $error("Eight-cycle settling wrong.");
  a_delay_ultra: assert property (
    settle_ultra |-> ##70 WAKE_DONE_O
  ) else $error("Seventy-cycle settling wrong.");
  a_plan_clear: assert property (
    armed_entry |=> !s_q.plan[spwc_pkg::PL_ARM] && SLEEPING_O
  ) else $error("Plan arm not cleared on entry.");
  a_plan_apply: assert property (
    armed_entry |=> SUPPLY_KEEP_O == {$past(s_q.plan[8:7]), $past(s_q.plan[4:0])}
  ) else $error("Planned supplies not applied.");
  a_run_supply: assert property (
    s_q.st == spwc_pkg::ST_RUN |-> SUPPLY_KEEP_O == 7'h7F && !SLEEPING_O
  ) else $error("Supply removed while running.");
  a_direct_path: assert property (
    DIRECT_SUPPLY_EN_O == !DCDC_EN_O
  ) else $error("Direct path and converter both on or off.");
  a_wake_blocked: assert property (
    s_q.st == spwc_pkg::ST_SLEEP && ev_now == 5'h00 && s_q.pend == 5'h00
    |=> s_q.st == spwc_pkg::ST_SLEEP
  ) else $error("Disabled source woke the block.");
  a_latch_pulse: assert property (
    s_q.st == spwc_pkg::ST_SLEEP && s_q.wake[spwc_pkg::WK_LATCH] && ev_now != 5'h00
    |=> s_q.st == spwc_pkg::ST_SETTLE && s_q.pend != 5'h00
  ) else $error("Short wake pulse lost.");
  a_bat_irq: assert property (
    ##1 BAT_LOW_IRQ_O == $past(BAT_LOW_I && s_d.bat[spwc_pkg::BT_LOW_IE])
  ) else $error("Low-voltage request not gated.");
  a_vlow_irq: assert property (
    ##1 BAT_VLOW_IRQ_O == $past(BAT_VLOW_I && s_d.bat[spwc_pkg::BT_VLOW_IE])
  ) else $error("Very-low-voltage request not gated.");
  // The shared bit 0 must never drive both of its roles at once.
  a_precision_det: assert property (
    BAT_HP_DET_EN_O == (!BAT_MON_EN_O && s_q.bat[spwc_pkg::BT_VTHX])
  ) else $error("Precision detection enable wrong.");
  a_threshold_msb: assert property (
    BAT_THR_MSB_O == (BAT_MON_EN_O && s_q.bat[spwc_pkg::BT_VTHX])
  ) else $error("Threshold top bit wrong.");
  // Software may write anything to the trim readback bits; nothing may stick there.
  a_aux_readonly: assert property (
    s_q.aux[15:8] == {4'h0, spwc_pkg::AUX_RO_BITS}
  ) else $error("Read-only auxiliary bits changed.");
  a_retain_run: assert property (
    s_q.st == spwc_pkg::ST_RUN |-> RETAIN_LEVEL_O == 2'b00
  ) else $error("Retention level applied while running.");
  // An interrupt-style entry must not let the either-edge input through.
  a_any_edge_gate: assert property (
    s_q.wake[spwc_pkg::WK_ANY_EDGE] && !s_q.wfe |-> !pin_evt
  ) else $error("Either-edge wake outside event entry.");

endmodule

// ### testbench/tb_top.sv
// Self-checking register and sleep sequence bench for the sleep power and wake control block.
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin failures++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
module tb_top;
  logic        clk = 1'b0;  // System clock, 40 MHz.
  logic        rst = 1'b1;  // Reset, held for six cycles.
  logic        psel = 1'b0, pen = 1'b0, pwr = 1'b0, err;
  logic        lp = 1'b0, rtc = 1'b0, fs = 1'b0, hs = 1'b0, blow = 1'b0;
  logic        wfe = 1'b0, pin = 1'b0, bvl = 1'b0;
  logic [2:0]  sram, trim;
  logic        bias, auxo, mon, thr, hp, vlowirq;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwd = 32'h0000_0000, rd;
  logic [31:0] prd;
  logic [15:0] gates;
  logic [6:0]  keep;
  logic [1:0]  lvl;
  logic        prdy, perr, slp, wdone, dcdc, direct, lowirq;
  int          failures = 0, compares = 0, n;

  spwc_top u_dut (.REF_CLK_I(clk), .SYS_RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwd), .PRDATA_O(prd), .PREADY_O(prdy),
    .PSLVERR_O(perr), .LP_ENTRY_I(lp), .LP_WFE_I(wfe), .PIN_EDGE_EVT_I(1'b0),
    .PIN_ANY_EDGE_I(pin), .RTC_EVT_I(rtc), .HSUSB_EVT_I(hs), .FSUSB_EVT_I(fs),
    .BAT_WAKE_EVT_I(1'b0), .BAT_LOW_I(blow), .BAT_VLOW_I(bvl), .PERIPH_CLK_OFF_O(gates),
    .SRAM_CLK_OFF_O(sram), .RETAIN_LEVEL_O(lvl), .DCDC_BIAS_EN_O(bias), .DCDC_EN_O(dcdc),
    .DIRECT_SUPPLY_EN_O(direct), .SUPPLY_KEEP_O(keep), .AUX_DCDC_EN_O(auxo),
    .ULP_TRIM_O(trim), .BAT_MON_EN_O(mon), .BAT_THR_MSB_O(thr), .BAT_HP_DET_EN_O(hp),
    .BAT_LOW_IRQ_O(lowirq), .BAT_VLOW_IRQ_O(vlowirq), .SLEEPING_O(slp), .WAKE_DONE_O(wdone));

  initial begin
    forever #12.5 clk = ~clk;
  end

  // One APB transfer; the request holds until pready is seen high at an edge.
  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwd <= wd;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
    end while (prdy !== 1'b1);
    rd = prd;
    err = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
    apb(1'b1, idx, wd);
  endtask

  task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0000_0000);
    `CHK(rd, exp)
  endtask

  task automatic wrap_up();
    if (failures == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // A hang is cut short well past the 167 cycles the sequence needs.
  initial begin
    repeat (3000) @(posedge clk);
    failures++;
    wrap_up();
  end

  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rdc(spwc_pkg::IDX_WAKE, 32'h0000_0020);
    rdc(spwc_pkg::IDX_PLAN, 32'h0000_11DF);
    wr(spwc_pkg::IDX_GATE_LO, 32'h0000_00FF);
    rdc(spwc_pkg::IDX_GATE_LO, 32'h0000_0000);
    apb(1'b0, 8'h30, 32'h0000_0000);
    `CHK(err, 1'b1)
    wr(spwc_pkg::IDX_SIG, 32'h0000_0057);
    wr(spwc_pkg::IDX_SIG, 32'h0000_00A8);
    wr(spwc_pkg::IDX_GATE_LO, 32'h0000_00A5);
    wr(spwc_pkg::IDX_GATE_HI, 32'h0000_005A);
    wr(spwc_pkg::IDX_WAKE, 32'h0000_0008);
    wr(spwc_pkg::IDX_PWR, 32'h0000_00E3);
    wr(spwc_pkg::IDX_BAT, 32'h0000_000B);
    wr(spwc_pkg::IDX_PLAN, 32'h0000_9714);
    wr(spwc_pkg::IDX_AUX, 32'h0000_0FA5);
    @(posedge clk);
    `CHK(gates, 16'h5AA5)
    `CHK({bias, dcdc, direct}, 3'b110)
    `CHK(sram, 3'b001)
    `CHK({auxo, trim}, 4'hD)
    `CHK({mon, thr, hp}, 3'b110)
    blow <= 1'b1;
    bvl <= 1'b1;
    repeat (2) @(posedge clk);
    `CHK({lowirq, vlowirq}, 2'b10)
    lp <= 1'b1;
    @(posedge clk);
    lp <= 1'b0;
    @(posedge clk);
    `CHK({slp, lvl, keep}, 10'h3D4)
    fs <= 1'b1;
    hs <= 1'b1;
    repeat (10) @(posedge clk);
    `CHK(slp, 1'b1)
    fs <= 1'b0;
    hs <= 1'b0;
    rtc <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wdone !== 1'b1 && n < 40);
    rtc <= 1'b0;
    `CHK(n, 10)
    `CHK(slp, 1'b0)
    rdc(spwc_pkg::IDX_PLAN, 32'h0000_1714);
    rdc(spwc_pkg::IDX_AUX, 32'h0000_00A5);
    wr(spwc_pkg::IDX_SIG, 32'h0000_0057);
    wr(spwc_pkg::IDX_SIG, 32'h0000_00A8);
    wr(spwc_pkg::IDX_WAKE, 32'h0000_00D4);
    wr(spwc_pkg::IDX_PWR, 32'h0000_0042);
    wr(spwc_pkg::IDX_BAT, 32'h0000_0005);
    wfe <= 1'b1;
    lp <= 1'b1;
    @(posedge clk);
    lp <= 1'b0;
    pin <= 1'b1;
    @(posedge clk);
    pin <= 1'b0;
    `CHK({mon, thr, hp, lowirq, vlowirq}, 5'h05)
    `CHK({slp, lvl, keep}, 10'h2FF)
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wdone !== 1'b1 && n < 100);
    `CHK(n, 71)
    `CHK(slp, 1'b0)
    wrap_up();
  end
endmodule
